// file: pwsd_pkg.sv
package pwsd_pkg;

    // ========================================
    // Register map
    localparam logic [0:0] PWSD_IDX_CONTROL = 1'h0;
    localparam logic [0:0] PWSD_IDX_ON_TIME_PERIOD = 1'h1;
    localparam int PWSD_REG_WIDTH = 16;
    localparam logic [15:0] PWSD_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] PWSD_ON_TIME_PERIOD_RESET = 16'h0000;

    // ========================================
    // Field positions in modulator_control
    localparam int PWSD_POS_RUN_ENABLE = 15;
    localparam int PWSD_POS_CLOCK_SELECT = 12;
    localparam int PWSD_POS_A_FOLLOW_HIGH = 11;
    localparam int PWSD_POS_A_FOLLOW_LOW = 10;
    localparam int PWSD_POS_B_FOLLOW_HIGH = 9;
    localparam int PWSD_POS_B_FOLLOW_LOW = 8;
    localparam int PWSD_POS_CHANGEOVER_1 = 7;
    localparam int PWSD_POS_CHANGEOVER_2 = 6;
    // Bits 5:0 are unused and read as zero
    localparam logic [15:0] PWSD_CONTROL_MASK = 16'hFFC0;

    // ========================================
    // Field positions in modulator_on_time_period
    localparam int PWSD_POS_ON_TIME = 8;
    localparam int PWSD_POS_PERIOD = 0;
    localparam int PWSD_COUNT_WIDTH = 8;

    // ========================================
    // Input clock generation
    localparam real PWSD_MCLK_KHZ = 25000.0;
    localparam int PWSD_ACC_WIDTH = 32;
    localparam logic [2:0] PWSD_SEL_RESET = 3'h0;
    // Selections below this code need the fast internal clock
    localparam logic [2:0] PWSD_SEL_FIRST_SLOW = 3'h3;
    // Increments are rate / 25 MHz scaled by 2^32, nearest integer, except 1228K8, which is one below
    localparam logic [31:0] PWSD_INC_4915K2 = 32'h3254E6E2;
    localparam logic [31:0] PWSD_INC_2457K6 = 32'h192A7371;
    localparam logic [31:0] PWSD_INC_1228K8 = 32'h0C9539B8;
    localparam logic [31:0] PWSD_INC_32K768 = 32'h0055E63C;
    localparam logic [31:0] PWSD_INC_8K192 = 32'h0015798F;
    localparam logic [31:0] PWSD_INC_1K024 = 32'h0002AF32;
    localparam logic [31:0] PWSD_INC_0K256 = 32'h0000ABCC;
    localparam logic [31:0] PWSD_INC_0K032 = 32'h0000157A;

    function automatic logic [31:0] pwsd_increment(input logic [2:0] sel);
        logic [31:0] inc;
        inc = PWSD_INC_0K032;
        unique case (sel)
            3'h0: inc = PWSD_INC_4915K2;
            3'h1: inc = PWSD_INC_2457K6;
            3'h2: inc = PWSD_INC_1228K8;
            3'h3: inc = PWSD_INC_32K768;
            3'h4: inc = PWSD_INC_8K192;
            3'h5: inc = PWSD_INC_1K024;
            3'h6: inc = PWSD_INC_0K256;
            3'h7: inc = PWSD_INC_0K032;
        endcase
        return inc;
    endfunction

    function automatic logic pwsd_needs_fast(input logic [2:0] sel);
        return sel < PWSD_SEL_FIRST_SLOW;
    endfunction

endpackage

// file: pwsd_tick_if.sv
`timescale 1ns/100ps
interface pwsd_tick_if;
    logic [2:0] clock_select;
    logic running;
    logic clock_available;
    logic tick;

    modport gen (
        input clock_select,
        input running,
        input clock_available,
        output tick
    );

    modport core (
        output clock_select,
        output running,
        output clock_available,
        input tick
    );
endinterface

// file: pwsd_clock_gen.sv
`timescale 1ns/100ps
module pwsd_clock_gen (
    input wire logic mclk_i,
    input wire logic srst_i,
    pwsd_tick_if.gen tick_if
);
    import pwsd_pkg::*;

    logic [PWSD_ACC_WIDTH-1:0] acc_reg;
    logic [PWSD_ACC_WIDTH-1:0] acc_next;
    logic tick_reg;
    logic tick_next;

    // ========================================
    // Phase accumulator; its carry is one input-clock cycle
    always_comb begin
        logic [PWSD_ACC_WIDTH:0] sum;
        sum = {1'b0, acc_reg} + {1'b0, pwsd_increment(tick_if.clock_select)}; // [RULE3]
        acc_next = sum[PWSD_ACC_WIDTH-1:0];
        tick_next = sum[PWSD_ACC_WIDTH];
        if (!tick_if.running || !tick_if.clock_available) begin
            // Restart phase so the first period is never short
            acc_next = '0;
            tick_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            acc_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_if.tick = tick_reg;
endmodule

// file: pwsd_top.sv
`timescale 1ns/100ps
// Overview of operation
// RULE1 - Runs only while run enable set; while sleeping the code runs from sleep_run_enable_i instead
// RULE2 - Software enables fast clock before fast selections
// RULE3 - Select field picks one of eight input rates
// RULE4 - Select field resets to zero
// RULE5 - Fast selections give no clock while sleeping
// RULE6 - Switch A closes in high phase
// RULE7 - Switch A closes in low phase
// RULE8 - Equal switch A bits release switch A
// RULE9 - Switch B closes in high phase
// RULE10 - Switch B closes in low phase
// RULE11 - Equal switch B bits release switch B
// RULE12 - High phase first, low phase fills rest
// RULE13 - Changeover 1 drive bit gates modulator in
// RULE14 - Changeover 2 drive bit gates modulator in
// RULE15 - Eight-bit counts in input-clock cycles
// RULE16 - On-time sets high phase and duty
// RULE17 - Period is period field plus one
// RULE18 - Duty is on-time plus one over period plus one
// RULE19 - Zero on-time or disabled gives zero duty
// RULE20 - Sleep enable replaces run enable while sleeping
// RULE21 - Free-running counter wraps at period value
// RULE22 - New counts apply at next period start
module pwsd_top (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic reg_write_i,
    input wire logic [0:0] reg_index_i,
    input wire logic [pwsd_pkg::PWSD_REG_WIDTH-1:0] reg_wdata_i,
    output logic [pwsd_pkg::PWSD_REG_WIDTH-1:0] reg_rdata_o,
    input wire logic sleep_i,
    input wire logic sleep_run_enable_i,
    input wire logic fast_internal_clock_on_i,
    input wire logic slow_clock_on_i,
    output logic modulator_o,
    output logic running_o,
    output logic analog_switch_a_close_o,
    output logic analog_switch_a_owned_o,
    output logic analog_switch_b_close_o,
    output logic analog_switch_b_owned_o,
    output logic changeover_switch_1_drive_o,
    output logic changeover_switch_1_owned_o,
    output logic changeover_switch_2_drive_o,
    output logic changeover_switch_2_owned_o
);
    import pwsd_pkg::*;

    localparam int CW = PWSD_COUNT_WIDTH;

    pwsd_tick_if tick_if ();

    // ========================================
    // Software-visible registers
    logic [PWSD_REG_WIDTH-1:0] control_reg;
    logic [PWSD_REG_WIDTH-1:0] control_next;
    logic [PWSD_REG_WIDTH-1:0] on_time_period_reg;
    logic [PWSD_REG_WIDTH-1:0] on_time_period_next;
    logic [PWSD_REG_WIDTH-1:0] rdata_reg;
    logic [PWSD_REG_WIDTH-1:0] rdata_next;

    always_comb begin
        control_next = control_reg;
        on_time_period_next = on_time_period_reg;
        if (reg_write_i) begin
            if (reg_index_i == PWSD_IDX_CONTROL) begin
                control_next = reg_wdata_i & PWSD_CONTROL_MASK;
            end else begin
                on_time_period_next = reg_wdata_i;
            end
        end
        rdata_next = (reg_index_i == PWSD_IDX_CONTROL) ? control_reg : on_time_period_reg;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            control_reg <= PWSD_CONTROL_RESET; // [RULE1] [RULE4]
            on_time_period_reg <= PWSD_ON_TIME_PERIOD_RESET;
            rdata_reg <= '0;
        end else begin
            control_reg <= control_next;
            on_time_period_reg <= on_time_period_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // ========================================
    // Field extraction
    logic run_enable;
    logic [2:0] input_clock_select;
    logic switch_a_follow_high;
    logic switch_a_follow_low;
    logic switch_b_follow_high;
    logic switch_b_follow_low;
    logic changeover_1_drive;
    logic changeover_2_drive;
    logic [CW-1:0] on_time_count;
    logic [CW-1:0] period_count;

    assign run_enable = control_reg[PWSD_POS_RUN_ENABLE];
    assign input_clock_select = control_reg[PWSD_POS_CLOCK_SELECT +: 3];
    assign switch_a_follow_high = control_reg[PWSD_POS_A_FOLLOW_HIGH];
    assign switch_a_follow_low = control_reg[PWSD_POS_A_FOLLOW_LOW];
    assign switch_b_follow_high = control_reg[PWSD_POS_B_FOLLOW_HIGH];
    assign switch_b_follow_low = control_reg[PWSD_POS_B_FOLLOW_LOW];
    assign changeover_1_drive = control_reg[PWSD_POS_CHANGEOVER_1];
    assign changeover_2_drive = control_reg[PWSD_POS_CHANGEOVER_2];
    assign on_time_count = on_time_period_reg[PWSD_POS_ON_TIME +: CW];
    assign period_count = on_time_period_reg[PWSD_POS_PERIOD +: CW];

    // ========================================
    // Run decision and input clock
    logic running;
    logic clock_available;

    // Sleep swaps in its own enable; run enable is then ignored
    assign running = sleep_i ? sleep_run_enable_i : run_enable; // [RULE1] [RULE20]
    // Fast rates vanish in sleep; a missing source simply gives no ticks
    assign clock_available = pwsd_needs_fast(input_clock_select)
        ? (fast_internal_clock_on_i && !sleep_i) // [RULE2] [RULE5]
        : slow_clock_on_i;

    assign tick_if.clock_select = input_clock_select;
    assign tick_if.running = running;
    assign tick_if.clock_available = clock_available;

    pwsd_clock_gen u_clock_gen (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .tick_if(tick_if)
    );

    // ========================================
    // Period counter with latched counts
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic [CW-1:0] on_latch_reg;
    logic [CW-1:0] on_latch_next;
    logic [CW-1:0] period_latch_reg;
    logic [CW-1:0] period_latch_next;
    logic out_reg;
    logic out_next;

    always_comb begin
        count_next = count_reg;
        on_latch_next = on_latch_reg;
        period_latch_next = period_latch_reg;
        if (!running) begin
            // Idle: stay at period start and track the registers
            count_next = '0;
            on_latch_next = on_time_count;
            period_latch_next = period_count;
        end else if (tick_if.tick) begin
            if (count_reg >= period_latch_reg) begin
                count_next = '0; // [RULE21] [RULE17]
                on_latch_next = on_time_count; // [RULE22]
                period_latch_next = period_count; // [RULE22]
            end else begin
                count_next = count_reg + 8'h01; // [RULE15]
            end
        end
        // High from count 0 through on-time; zero on-time means always off
        out_next = running && (on_latch_next != '0) // [RULE19]
            && (count_next <= on_latch_next); // [RULE12] [RULE16] [RULE18]
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            count_reg <= '0;
            on_latch_reg <= '0;
            period_latch_reg <= '0;
            out_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            on_latch_reg <= on_latch_next;
            period_latch_reg <= period_latch_next;
            out_reg <= out_next;
        end
    end

    // ========================================
    // Switch steering
    logic sw_a_close_next;
    logic sw_b_close_next;
    logic [4:0] steer_reg;
    logic [4:0] steer_next;

    always_comb begin
        sw_a_close_next = switch_a_follow_high ? out_next : !out_next; // [RULE6] [RULE7]
        sw_b_close_next = switch_b_follow_high ? out_next : !out_next; // [RULE9] [RULE10]
        steer_next[0] = (switch_a_follow_high != switch_a_follow_low) && sw_a_close_next; // [RULE8]
        steer_next[1] = (switch_b_follow_high != switch_b_follow_low) && sw_b_close_next; // [RULE11]
        steer_next[2] = changeover_1_drive && out_next; // [RULE13]
        steer_next[3] = changeover_2_drive && out_next; // [RULE14]
        steer_next[4] = running;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            steer_reg <= '0;
        end else begin
            steer_reg <= steer_next;
        end
    end

    assign modulator_o = out_reg;
    assign running_o = steer_reg[4];
    assign analog_switch_a_close_o = steer_reg[0];
    assign analog_switch_b_close_o = steer_reg[1];
    assign changeover_switch_1_drive_o = steer_reg[2];
    assign changeover_switch_2_drive_o = steer_reg[3];
    // Ownership flags tell the switch mux whose control to use
    assign analog_switch_a_owned_o = switch_a_follow_high != switch_a_follow_low; // [RULE8]
    assign analog_switch_b_owned_o = switch_b_follow_high != switch_b_follow_low; // [RULE11]
    assign changeover_switch_1_owned_o = changeover_1_drive; // [RULE13]
    assign changeover_switch_2_owned_o = changeover_2_drive; // [RULE14]
endmodule

// file: pwsd_clk_model.sv
`timescale 1ns/100ps
// ========================================
// Clock sources seen by the modulator
module pwsd_clk_model (
    input wire logic sleep_i,
    input wire logic fast_req_i,
    output logic fast_on_o,
    output logic slow_on_o
);
    // Fast oscillator is shut down in sleep whatever software asked
    assign fast_on_o = fast_req_i & ~sleep_i;
    assign slow_on_o = 1'b1;
endmodule

// file: pwsd_top_sva.sv
`timescale 1ns/100ps
module pwsd_top_sva
    import pwsd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic reg_write_i,
    input wire logic [0:0] reg_index_i,
    input wire logic [pwsd_pkg::PWSD_REG_WIDTH-1:0] reg_wdata_i,
    input wire logic [pwsd_pkg::PWSD_REG_WIDTH-1:0] reg_rdata_o,
    input wire logic sleep_i,
    input wire logic sleep_run_enable_i,
    input wire logic modulator_o,
    input wire logic running_o,
    input wire logic analog_switch_a_close_o,
    input wire logic analog_switch_a_owned_o,
    input wire logic analog_switch_b_close_o,
    input wire logic analog_switch_b_owned_o,
    input wire logic changeover_switch_1_drive_o,
    input wire logic changeover_switch_1_owned_o,
    input wire logic changeover_switch_2_drive_o,
    input wire logic changeover_switch_2_owned_o
);
    // ========================================
    // Shadow copies of both registers
    logic [15:0] ctrl_reg, ctrl_next, thtp_reg, thtp_next;
    always_comb begin
        ctrl_next = ctrl_reg;
        thtp_next = thtp_reg;
        if (reg_write_i && reg_index_i == PWSD_IDX_CONTROL) begin
            ctrl_next = reg_wdata_i & PWSD_CONTROL_MASK;
        end
        if (reg_write_i && reg_index_i == PWSD_IDX_ON_TIME_PERIOD) begin
            thtp_next = reg_wdata_i;
        end
    end
    always_ff @(posedge mclk_i) begin
        ctrl_reg <= srst_i ? PWSD_CONTROL_RESET : ctrl_next;
        thtp_reg <= srst_i ? PWSD_ON_TIME_PERIOD_RESET : thtp_next;
    end
    logic run_want;
    logic fast_sel;
    assign run_want = sleep_i ? sleep_run_enable_i : ctrl_reg[15];
    assign fast_sel = ctrl_reg[14:12] < PWSD_SEL_FIRST_SLOW;
    // ========================================
    // Properties
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    chk_owned_a: assert property (analog_switch_a_owned_o == (ctrl_reg[11] ^ ctrl_reg[10]))
        else $error("switch a ownership wrong");
    chk_close_a: assert property ($stable(ctrl_reg) |-> analog_switch_a_close_o ==
        (analog_switch_a_owned_o && (ctrl_reg[11] ? modulator_o : !modulator_o)))
        else $error("switch a state wrong");
    chk_owned_b: assert property (analog_switch_b_owned_o == (ctrl_reg[9] ^ ctrl_reg[8]))
        else $error("switch b ownership wrong");
    chk_close_b: assert property ($stable(ctrl_reg) |-> analog_switch_b_close_o ==
        (analog_switch_b_owned_o && (ctrl_reg[9] ? modulator_o : !modulator_o)))
        else $error("switch b state wrong");
    chk_changeover_one: assert property ($stable(ctrl_reg) |-> changeover_switch_1_owned_o ==
        ctrl_reg[7] && changeover_switch_1_drive_o == (ctrl_reg[7] && modulator_o))
        else $error("changeover 1 drive wrong");
    chk_changeover_two: assert property ($stable(ctrl_reg) |-> changeover_switch_2_owned_o ==
        ctrl_reg[6] && changeover_switch_2_drive_o == (ctrl_reg[6] && modulator_o))
        else $error("changeover 2 drive wrong");
    chk_read_back: assert property (reg_rdata_o ==
        ($past(reg_index_i) == PWSD_IDX_CONTROL ? $past(ctrl_reg) : $past(thtp_reg)))
        else $error("read data wrong");
    chk_run_state: assert property (!$past(srst_i) |->
        running_o == $past(run_want))
        else $error("run state wrong");
    chk_stopped_low: assert property (!running_o && !$past(running_o) |-> !modulator_o)
        else $error("output high while stopped");
    // Output lags the select by two edges (tick register, then output), so the select two samples back decides
    chk_sleep_freeze: assert property ($past(sleep_i, 2) && $past(fast_sel, 2)
        && running_o && $past(running_o) |-> $stable(modulator_o))
        else $error("fast selection ticks in sleep");
endmodule

bind pwsd_top pwsd_top_sva u_pwsd_top_sva (.*);

// file: test_pwm_switch_driver.sv
`timescale 1ns/100ps
module test_pwm_switch_driver;
    import pwsd_pkg::*;
    logic mclk_i = 1'b0, srst_i = 1'b1, reg_write_i = 1'b0, sleep_i = 1'b0, slp_run = 1'b0;
    logic [0:0] reg_index_i = 1'h0;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
    logic fast_req = 1'b0, fast_on, slow_on, modulator_o, running_o;
    logic a_cl, a_own, b_cl, b_own, c1_dr, c1_own, c2_dr, c2_own;
    int fails = 0, comparisons = 0, hi, lo, n;
    real rates [5] = '{4915.2, 2457.6, 1228.8, 32.768, 8.192};

    pwsd_clk_model u_pwsd_clk_model (.sleep_i(sleep_i), .fast_req_i(fast_req),
        .fast_on_o(fast_on), .slow_on_o(slow_on));
    pwsd_top u_pwsd_top (.mclk_i(mclk_i), .srst_i(srst_i), .reg_write_i(reg_write_i),
        .reg_index_i(reg_index_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .sleep_i(sleep_i), .sleep_run_enable_i(slp_run), .fast_internal_clock_on_i(fast_on),
        .slow_clock_on_i(slow_on), .modulator_o(modulator_o), .running_o(running_o),
        .analog_switch_a_close_o(a_cl), .analog_switch_a_owned_o(a_own),
        .analog_switch_b_close_o(b_cl), .analog_switch_b_owned_o(b_own),
        .changeover_switch_1_drive_o(c1_dr), .changeover_switch_1_owned_o(c1_own),
        .changeover_switch_2_drive_o(c2_dr), .changeover_switch_2_owned_o(c2_own));

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    // ========================================
    // Access and measuring tasks
    task automatic end_sim();
        if (fails == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            fails++;
        end
    endtask
    // One mclk cycle of NCO jitter on each edge
    task automatic near(string name, real exp, int got);
        comparisons++;
        if (got < exp - 2.0 || got > exp + 2.0) begin
            $display("unexpected %s: expected %f, seen %0d", name, exp, got);
            fails++;
        end
    endtask
    task automatic wr(logic [0:0] idx, logic [15:0] d);
        @(negedge mclk_i);
        reg_write_i = 1'b1;
        reg_index_i = idx;
        reg_wdata_i = d;
        @(negedge mclk_i);
        reg_write_i = 1'b0;
    endtask
    task automatic rd(logic [0:0] idx, logic [15:0] exp);
        @(negedge mclk_i);
        reg_index_i = idx;
        repeat (2) @(negedge mclk_i);
        check("read data", exp, reg_rdata_o);
    endtask
    task automatic wait_mod(logic v, output int k);
        k = 0;
        while (modulator_o !== v) begin
            @(negedge mclk_i);
            k++;
            if (k > 30000) begin
                fails++;
                end_sim();
            end
        end
    endtask
    // On-time 1 and period 2 give 2 of 3 ticks high
    task automatic measure(real khz);
        wait_mod(1'b0, n);
        wait_mod(1'b1, n);
        wait_mod(1'b0, hi);
        wait_mod(1'b1, lo);
        near("high time", 2.0 * 25000.0 / khz, hi);
        near("period", 3.0 * 25000.0 / khz, hi + lo);
    endtask
    task automatic count_high(output int k);
        k = 0;
        repeat (100) begin
            @(negedge mclk_i);
            k += int'(modulator_o === 1'b1);
        end
    endtask
    // ========================================
    // Main sequence
    initial begin
        repeat (16) @(negedge mclk_i);
        srst_i = 1'b0;
        rd(PWSD_IDX_CONTROL, 16'h0000);
        rd(PWSD_IDX_ON_TIME_PERIOD, 16'h0000);
        wr(PWSD_IDX_CONTROL, 16'hFFFF);
        rd(PWSD_IDX_CONTROL, 16'hFFC0);
        wr(PWSD_IDX_ON_TIME_PERIOD, 16'hA55A);
        rd(PWSD_IDX_ON_TIME_PERIOD, 16'hA55A);
        fast_req = 1'b1;
        wr(PWSD_IDX_ON_TIME_PERIOD, 16'h0102);
        for (int s = 0; s < 5; s++) begin
            wr(PWSD_IDX_CONTROL, 16'h8000 | 16'(s << 12));
            measure(rates[s]);
        end
        for (int i = 0; i < 64; i++) begin
            wr(PWSD_IDX_CONTROL, 16'h8000 | 16'(i << 6));
            repeat (20) @(negedge mclk_i);
            check("owned flags", 16'({i[5] ^ i[4], i[3] ^ i[2], i[1:0]}),
                16'({a_own, b_own, c1_own, c2_own}));
            check("switch states", 16'({(i[5] ^ i[4]) && (i[5] ? modulator_o : !modulator_o),
                (i[3] ^ i[2]) && (i[3] ? modulator_o : !modulator_o), i[1] && modulator_o,
                i[0] && modulator_o}), 16'({a_cl, b_cl, c1_dr, c2_dr}));
        end
        wr(PWSD_IDX_ON_TIME_PERIOD, 16'h0002);
        repeat (60) @(negedge mclk_i);
        count_high(n);
        check("high count zero on", 16'd0, 16'(n));
        wr(PWSD_IDX_ON_TIME_PERIOD, 16'h0302);
        repeat (60) @(negedge mclk_i);
        count_high(n);
        check("high count full", 16'd100, 16'(n));
        sleep_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        check("running asleep", 16'd0, 16'(running_o));
        wr(PWSD_IDX_ON_TIME_PERIOD, 16'h0102);
        slp_run = 1'b1;
        repeat (3) @(negedge mclk_i);
        check("running asleep", 16'd1, 16'(running_o));
        // Fast select still set: no ticks, so the first high phase never ends
        count_high(n);
        check("high count fast asleep", 16'd100, 16'(n));
        wr(PWSD_IDX_CONTROL, 16'h3000);
        measure(rates[3]);
        sleep_i = 1'b0;
        wr(PWSD_IDX_CONTROL, 16'h0000);
        repeat (3) @(negedge mclk_i);
        count_high(n);
        check("high count stopped", 16'd0, 16'(n));
        end_sim();
    end
endmodule
